// [core/edc_pkg.sv]
// Package for the extended block command registers
package edc_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [4:0] OFS_EXT0   = 5'h00;
  localparam logic [4:0] OFS_EXT1   = 5'h04;
  localparam logic [4:0] OFS_EXT2   = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_CTRL   = 5'h10;

  // Supplemental-block field position and codes
  localparam int         SUPP_LSB    = 25;
  localparam logic [1:0] SUPP_EXT0   = 2'h2;
  localparam logic [1:0] SUPP_EXT012 = 2'h3;

  // Per-block command field layout
  localparam int         FIELD_W     = 3;
  localparam int         FIELD_LSB   = 1;
  localparam int         FIELDS      = 8;
  localparam int         REG_USED_W  = 24;
  localparam logic [2:0] CMD_NULL    = 3'h0;
  localparam logic [2:0] CMD_XOR     = 3'h1;

  // Reset values
  localparam logic [31:0] EXT_RESET  = 32'h0000_0000;
  localparam logic        CTRL_RESET = 1'b1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Descriptor load request from the fetch logic
  typedef struct packed {
    logic        valid;
    logic [31:0] main_ctrl;
    logic [31:0] word0;
    logic [31:0] word1;
    logic [31:0] word2;
  } edc_load_s;

  // Per-block selects towards the datapath (blocks 9..32)
  typedef struct packed {
    logic [23:0] fetch;
    logic [23:0] bad;
  } edc_sel_s;

endpackage

// [core/edc_field_dec.sv]
// Decoder for one register's eight block command fields
`timescale 1ns/1ps
module edc_field_dec
  import edc_pkg::*;
(
  // Register value
  input  wire logic [31:0] REG_VAL,
  // Per-block outputs
  output logic [7:0]       FETCH,
  output logic [7:0]       BAD
);

  // Each field: XOR fetches, null skips, anything else is flagged
  always_comb begin
    for (int i = 0; i < FIELDS; i++) begin
      FETCH[i] = (REG_VAL[FIELD_LSB + FIELD_W*i +: FIELD_W] == CMD_XOR);
      BAD[i]   = (REG_VAL[FIELD_LSB + FIELD_W*i +: FIELD_W] != CMD_XOR) &&
                 (REG_VAL[FIELD_LSB + FIELD_W*i +: FIELD_W] != CMD_NULL);
    end
  end

endmodule // edc_field_dec

// [core/edc_regs.sv]
// Extended block command register bank with AXI4-Lite read access
//
// What this block does
// - Load register 0 for sixteen-plus sources
// - Register 0 governs blocks nine to sixteen
// - Register 0 fields: block 9 bits 3:1 upward
// - Load register 1 for thirty-two sources
// - Register 1 fields: block 17 bits 3:1 upward
// - Load register 2 for thirty-two sources
// - Command 000 skips block, no reads
// - Command 001 fetches block for XOR
// - Main control bits 26:25 select loading
// - Read-only; reloaded on each applicable descriptor
// - Code 10 one extension, 11 three
// - Register 2 fields: block 25 bits 3:1 upward
`timescale 1ns/1ps
module edc_regs
  import edc_pkg::*;
(
  // Clock, enable, reset
  input  wire logic        CLK,
  input  wire logic        CE,
  input  wire logic        RSTN,
  // Descriptor load from fetch logic
  input  wire edc_load_s   LOAD,
  // Block selects towards the datapath
  output edc_sel_s         SEL,
  // AXI4-Lite write address
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [4:0]  S_AXI_AWADDR,
  // AXI4-Lite write data
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  // AXI4-Lite read address
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [4:0]  S_AXI_ARADDR,
  // AXI4-Lite read data
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP
);

  // All state of the block except the captured control write bit
  typedef struct packed {
    logic [31:0] ext0;      // Blocks 9..16
    logic [31:0] ext1;      // Blocks 17..24
    logic [31:0] ext2;      // Blocks 25..32
    logic [1:0]  last_supp; // Supplemental code of last load
    logic [7:0]  load_cnt;  // Loads seen, wraps
    logic        ctrl_en;   // Software load enable
    logic        aw_got;    // Write address held
    logic        w_got;     // Write data held
    logic [4:0]  aw_addr;   // Held write address
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    edc_sel_s    sel;
  } edc_state_s;

  edc_state_s st;       // Registered state
  edc_state_s next_st;  // Next state

  // Decoded selects for all three registers
  logic [23:0] fetch_w;
  logic [23:0] bad_w;
  logic [1:0]  supp;    // Supplemental-block code from main control
  logic        ld0;     // Load register 0
  logic        ld12;    // Load registers 1 and 2
  logic [31:0] rd_val;  // Read mux output
  logic        rd_ok;   // Read address mapped

  // Field mask keeping bits 24:1, zero above and at bit 0
  localparam logic [31:0] USED_MASK = 32'h01ff_fffe;

  // One decoder per register; decoding the held value keeps the selects
  // one cycle behind the registers and avoids a loop through next_st
  for (genvar g = 0; g < 3; g++) begin : g_dec
    edc_field_dec u_dec (
      .REG_VAL (g == 0 ? st.ext0 : (g == 1 ? st.ext1 : st.ext2)),
      .FETCH   (fetch_w[8*g +: 8]),
      .BAD     (bad_w[8*g +: 8])
    );
  end

  // Load qualification from supplemental code
  always_comb begin
    supp = LOAD.main_ctrl[SUPP_LSB +: 2];
    ld0  = LOAD.valid && st.ctrl_en &&
           ((supp == SUPP_EXT0) || (supp == SUPP_EXT012));
    ld12 = LOAD.valid && st.ctrl_en && (supp == SUPP_EXT012);
  end

  // Read mux
  always_comb begin
    rd_ok  = 1'b1;
    unique case (S_AXI_ARADDR[4:0])
      OFS_EXT0:   rd_val = st.ext0;
      OFS_EXT1:   rd_val = st.ext1;
      OFS_EXT2:   rd_val = st.ext2;
      OFS_STATUS: rd_val = {22'h0, st.last_supp, st.load_cnt};
      OFS_CTRL:   rd_val = {31'h0, st.ctrl_en};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    // Descriptor loads; each applicable fetch replaces old values
    if (ld0) begin
      next_st.ext0 = LOAD.word0 & USED_MASK;
    end
    if (ld12) begin
      next_st.ext1 = LOAD.word1 & USED_MASK;
      next_st.ext2 = LOAD.word2 & USED_MASK;
    end
    if (ld0) begin
      next_st.last_supp = supp;
      next_st.load_cnt  = st.load_cnt + 8'h01;
    end
    // Selects follow the register contents
    next_st.sel.fetch = fetch_w;
    next_st.sel.bad   = bad_w;
    // Write channel capture, either order
    if (S_AXI_AWVALID && !st.aw_got && !st.bvalid) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st.w_got && !st.bvalid) begin
      next_st.w_got = 1'b1;
    end
    // Write completes: only control is writable, extension registers stay read-only
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.aw_addr == OFS_CTRL) begin
        next_st.bresp = RESP_OKAY;
      end else if (st.aw_addr[4:2] <= 3'h3) begin
        next_st.bresp = RESP_SLVERR;
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end
    // Read channel
    next_st.arready = 1'b0;
    if (S_AXI_ARVALID && !st.arready && !st.rvalid) begin
      next_st.arready = 1'b1;
      next_st.rvalid  = 1'b1;
      next_st.rdata   = rd_val;
      next_st.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end
  end

  // Control write data capture
  logic        wr_ctrl;   // Control write happens this cycle
  logic        wdat_ctrl; // Captured data bit
  logic        next_wdat;
  always_comb begin
    wr_ctrl   = st.aw_got && st.w_got && !st.bvalid && (st.aw_addr == OFS_CTRL);
    next_wdat = wdat_ctrl;
    if (S_AXI_WVALID && !st.w_got && !st.bvalid && S_AXI_WSTRB[0]) begin
      next_wdat = S_AXI_WDATA[0];
    end else if (S_AXI_WVALID && !st.w_got && !st.bvalid) begin
      next_wdat = st.ctrl_en;
    end
  end

  // State register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st         <= '0;
      st.ext0    <= EXT_RESET;
      st.ext1    <= EXT_RESET;
      st.ext2    <= EXT_RESET;
      st.ctrl_en <= CTRL_RESET;
      wdat_ctrl  <= CTRL_RESET;
    end else if (CE) begin
      st        <= next_st;
      wdat_ctrl <= next_wdat;
      if (wr_ctrl) begin
        st.ctrl_en <= wdat_ctrl;
      end
    end
  end

  // Outputs from flip-flops; write address and write data ready are gated from two flip-flops each
  assign SEL           = st.sel;
  assign S_AXI_AWREADY = !st.aw_got && !st.bvalid;
  assign S_AXI_WREADY  = !st.w_got && !st.bvalid;
  assign S_AXI_BVALID  = st.bvalid;
  assign S_AXI_BRESP   = st.bresp;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RVALID  = st.rvalid;
  assign S_AXI_RDATA   = st.rdata;
  assign S_AXI_RRESP   = st.rresp;

  // Assertions
  sequence s_load0;
    CE && LOAD.valid && st.ctrl_en && LOAD.main_ctrl[26:25] >= 2'h2;
  endsequence

  sequence s_load12;
    CE && LOAD.valid && st.ctrl_en && LOAD.main_ctrl[26:25] == 2'h3;
  endsequence

  ext0_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
    s_load0 |=> st.ext0 == ($past(LOAD.word0) & 32'h01ff_fffe))
    else $error("ext0 not loaded");

  ext12_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
    s_load12 |=> st.ext1 == ($past(LOAD.word1) & 32'h01ff_fffe))
    else $error("ext1 not loaded");

  ext2_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
    s_load12 |=> st.ext2 == ($past(LOAD.word2) & 32'h01ff_fffe))
    else $error("ext2 not loaded");

  ext0_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (LOAD.main_ctrl[26:25] < 2'h2) |=> $stable(st.ext0))
    else $error("ext0 changed without extension");

  ext12_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    (LOAD.main_ctrl[26:25] != 2'h3) |=> $stable(st.ext1) && $stable(st.ext2))
    else $error("ext1/2 changed without three extensions");

  zero_bits_a: assert property (@(posedge CLK) disable iff (!RSTN)
    st.ext0[31:25] == 7'h0 && st.ext0[0] == 1'b0 && st.ext2[0] == 1'b0)
    else $error("reserved bits set");

  null_skip_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && st.ext0[3:1] == 3'h0 |=> !SEL.fetch[0])
    else $error("null block fetched");

  xor_fetch_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && st.ext1[15:13] == 3'h1 |=> SEL.fetch[12])
    else $error("xor block not fetched");

  read_back_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && S_AXI_ARVALID && !st.arready && !st.rvalid && S_AXI_ARADDR == 5'h0
    |=> S_AXI_RVALID && S_AXI_RDATA == $past(st.ext0))
    else $error("ext0 readback wrong");

  // Frozen enable keeps every bit of state
  freeze_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    !CE |=> $stable(st))
    else $error("state moved while frozen");

  // Register 0 only moves on an applicable load
  ext0_only_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !ld0 |=> $stable(st.ext0))
    else $error("ext0 moved without load");

  // Registers 1 and 2 only move on a three-extension load
  ext12_only_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !ld12 |=> $stable(st.ext1) && $stable(st.ext2))
    else $error("ext1/2 moved without load");

  // Loading switched off leaves all three registers alone
  load_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && !st.ctrl_en |=> $stable(st.ext0) && $stable(st.ext1) && $stable(st.ext2))
    else $error("load taken while disabled");

  // Upper bits of registers 1 and 2 and lowest bit of register 1 stay clear
  zero_bits12_a: assert property (@(posedge CLK) disable iff (!RSTN)
    st.ext1[31:25] == 7'h0 && st.ext1[0] == 1'b0 && st.ext2[31:25] == 7'h0)
    else $error("reserved bits set in ext1/2");

  // Top field of register 2 fetches on XOR
  xor_top_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && st.ext2[24:22] == 3'h1 |=> SEL.fetch[23])
    else $error("block 32 xor not fetched");

  // Top field of register 1 skips on null
  null_top_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && st.ext1[24:22] == 3'h0 |=> !SEL.fetch[15] && !SEL.bad[15])
    else $error("block 24 null fetched");

  // Reserved code in register 2 is flagged
  bad_code_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && st.ext2[3:1] > 3'h1 |=> SEL.bad[16] && !SEL.fetch[16])
    else $error("reserved code not flagged");

  // Block 25 sits in bits 3:1 of register 2
  ext2_low_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && st.ext2[3:1] == 3'h1 |=> SEL.fetch[16])
    else $error("block 25 field misplaced");

  // Supplemental code of the last load is kept for status
  last_supp_a: assert property (@(posedge CLK) disable iff (!RSTN)
    s_load0 |=> st.last_supp == $past(LOAD.main_ctrl[26:25]))
    else $error("last code not kept");

  // A finished write to a command register is refused
  write_refused_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && st.aw_got && st.w_got && !st.bvalid && st.aw_addr != OFS_CTRL
    |=> S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR)
    else $error("command register write accepted");

  // Write response stands until it is taken
  bvalid_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");

  // Read data stands until it is taken
  rvalid_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");

  // Read address ready lasts a single cycle
  arready_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && S_AXI_ARREADY |=> !S_AXI_ARREADY)
    else $error("arready held");

  // Unmapped read answers an error with zero data
  read_err_a: assert property (@(posedge CLK) disable iff (!RSTN)
    CE && S_AXI_ARVALID && !st.arready && !st.rvalid && S_AXI_ARADDR > 5'h10
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");

endmodule // edc_regs

// [bench/edc_fetch_model.sv]
// Descriptor fetch model feeding load requests to the bank
`timescale 1ns/1ps
module edc_fetch_model
  import edc_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Load request towards the bank
  output edc_load_s load
);
  // Idle until the first request
  initial load = '0;

  // Build an extension word; fields carry null or XOR unless bad is asked
  function automatic logic [31:0] mk(input logic [31:0] raw, input logic bad);
    mk = raw;
    for (int n = 0; n < FIELDS; n++) begin
      mk[FIELD_LSB + FIELD_W * n +: FIELD_W] = {2'b00, raw[n]};
    end
    // Deliberate reserved code in the lowest field
    if (bad) begin
      mk[FIELD_LSB +: FIELD_W] = 3'h2 | raw[2:0];
    end
  endfunction

  // Raise the load request with the supplemental code in place; it stays up until idle() drops it
  task automatic send(input logic [1:0] code, input logic [31:0] misc,
                      input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
    @(posedge clk);
    load <= '{1'b1, {misc[31:27], code, misc[24:0]}, w0, w1, w2};
  endtask

  // Drop the request; inverted payload so stale words never look fresh
  task automatic idle();
    @(posedge clk);
    load <= '{1'b0, ~load.main_ctrl, ~load.word0, ~load.word1, ~load.word2};
  endtask
endmodule // edc_fetch_model

// [bench/tb_extended_descriptor_control_regs.sv]
// Self-checking bench for the extended block command register bank
`timescale 1ns/1ps
module tb_extended_descriptor_control_regs
  import edc_pkg::*;
  ;
  localparam logic [31:0] MASK = 32'h01ff_fffe;
  logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1;
  edc_load_s   load;
  edc_sel_s    sel;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        awr, wr, bv, arr, rv;
  logic [4:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0, rd, d, seed = 32'h491d;
  logic [3:0]  ws = '0;
  logic [1:0]  bresp, rresp, r, c;
  logic [31:0] ex [3];
  int          n_errors = 0, compares = 0, nld = 0;
  logic [1:0]  lsupp = '0;

  // 10 MHz clock
  always #50 clk = ~clk;

  // Far side and device
  edc_fetch_model u_fm (.clk(clk), .load(load));
  edc_regs u_dut (.CLK(clk), .CE(ce), .RSTN(rstn), .LOAD(load), .SEL(sel),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp));

  // Xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected block selects from the shadow registers
  function automatic edc_sel_s exp_sel();
    logic [2:0] f;
    exp_sel = '0;
    for (int i = 0; i < 24; i++) begin
      f = ex[i / 8][3 * (i % 8) + 1 +: 3];
      exp_sel.fetch[i] = (f == CMD_XOR);
      exp_sel.bad[i] = (f > CMD_XOR);
    end
  endfunction

  // Compare and count
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // AXI4-Lite write; ready sampled at the falling edge before the edge it qualifies
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= v;
    ws <= 4'hf;
    br <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = br && bv;
      rs = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) br <= 1'b0;
    end
  endtask

  // AXI4-Lite read
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rr && rv;
      v = rd;
      rs = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) rr <= 1'b0;
    end
  endtask

  // Selects one edge after the load, then all three registers
  task automatic chk_all();
    @(posedge clk);
    @(negedge clk);
    cmp(sel, exp_sel());
    for (int k = 0; k < 3; k++) begin
      axi_rd(5'(4 * k), d, r);
      cmp(d, ex[k]);
      cmp(r, RESP_OKAY);
    end
    axi_rd(5'(OFS_STATUS), d, r);
    cmp(d, {22'h0, lsupp, 8'(nld)});
  endtask

  // One load; shadow copy follows when it should be taken
  task automatic load_one(input logic [1:0] cd, input logic bad, input logic take);
    logic [31:0] w [3];
    for (int k = 0; k < 3; k++) w[k] = u_fm.mk(xs(), bad);
    u_fm.send(cd, xs(), w[0], w[1], w[2]);
    if (take && cd[1]) begin
      nld++;
      lsupp = cd;
    end
    if (take && cd == SUPP_EXT0) ex[0] = w[0] & MASK;
    if (take && cd == SUPP_EXT012) ex = '{w[0] & MASK, w[1] & MASK, w[2] & MASK};
  endtask

  // Watchdog
  initial begin
    #2_000_000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    ex = '{EXT_RESET, EXT_RESET, EXT_RESET};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, then one unmapped place
    for (int k = 0; k < 6; k++) begin
      axi_rd(5'(4 * k), d, r);
      cmp(d, (k == 4) ? 32'h1 : 32'h0);
      cmp(r, (k == 5) ? RESP_SLVERR : RESP_OKAY);
    end
    // Software cannot write a command register
    axi_wr(5'(OFS_EXT0), 32'hffff_ffff, r);
    cmp(r, RESP_SLVERR);
    // Every code once, then random ones, some back to back
    for (int i = 0; i < 24; i++) begin
      c = (i < 4) ? 2'(i) : 2'(xs());
      load_one(c, i % 5 == 0, 1'b1);
      if (i % 3 == 0) load_one(SUPP_EXT012, 1'b0, 1'b1);
      u_fm.idle();
      chk_all();
    end
    // Frozen enable ignores a descriptor
    ce <= 1'b0;
    load_one(SUPP_EXT012, 1'b0, 1'b0);
    u_fm.idle();
    ce <= 1'b1;
    chk_all();
    // Loading switched off, then on again
    axi_wr(5'(OFS_CTRL), 32'h0, r);
    cmp(r, RESP_OKAY);
    axi_rd(5'(OFS_CTRL), d, r);
    cmp(d, 32'h0);
    load_one(SUPP_EXT012, 1'b0, 1'b0);
    u_fm.idle();
    chk_all();
    axi_wr(5'(OFS_CTRL), 32'h1, r);
    cmp(r, RESP_OKAY);
    load_one(SUPP_EXT0, 1'b0, 1'b1);
    u_fm.idle();
    chk_all();
    report_and_stop();
  end
endmodule // tb_extended_descriptor_control_regs
